// *** design/self_test_ctrl.sv ***
// Self-test control register: SRAM test engine control, EEPROM reload and check.
// Assumes the SRAM test engine, EEPROM word reader and config registers sit outside.
`timescale 1ns/1ps
`default_nettype none

module self_test_ctrl #(
   parameter int RELOAD_CYCLES_P = self_test_pkg::RELOAD_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic SOFT_RST,
   input wire self_test_pkg::bus_req_t BUS_REQ,
   output logic [self_test_pkg::DATA_W-1:0] RDATA,
   output logic IRQ,
   output logic SRAM_TEST_RST,
   output logic SRAM_TEST_RUN,
   input wire logic SRAM_TEST_END,
   input wire self_test_pkg::sram_fault_t SRAM_FAULTS,
   output logic EE_REQ,
   output logic [3:0] EE_ADDR,
   input wire logic EE_ACK,
   input wire logic [15:0] EE_DATA,
   output self_test_pkg::cfg_wr_t CFG_WR
);
   import self_test_pkg::*;

   // Adds both bytes of a word to the running 8-bit sum
   function automatic logic [7:0] byte_sum(input logic [7:0] acc, input logic [15:0] word);
      byte_sum = acc + word[15:8] + word[7:0];
   endfunction

   localparam logic [TIMER_W-1:0] RELOAD_LAST = TIMER_W'(RELOAD_CYCLES_P - 1);

   logic sram_rst_reg, sram_rst_next;
   logic sram_run_reg, sram_run_next;
   logic fin_reg, fin_next;
   sram_fault_t fault_reg, fault_next;
   logic [EV_W-1:0] status_reg, status_next;
   logic [EV_W-1:0] mask_reg, mask_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   ee_state_t state_reg, state_next;
   logic reload_mode_reg, reload_mode_next;
   logic bad_reg, bad_next;
   logic [3:0] word_reg, word_next;
   logic [7:0] acc_reg, acc_next;
   logic [TIMER_W-1:0] timer_reg, timer_next;
   cfg_wr_t cfg_reg, cfg_next;

   logic ctrl_wr, status_wr, mask_wr;
   logic start_rise, sram_event, check_event, reload_event;
   logic reload_busy, check_busy;
   logic [7:0] final_sum;

   // Address decode
   assign ctrl_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_SELF_TEST_CONTROL);
   assign status_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_EVENT_STATUS);
   assign mask_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_EVENT_MASK);

   // Busy indicators of the EEPROM sequencer
   assign reload_busy = (state_reg != EE_IDLE) && reload_mode_reg;
   assign check_busy = (state_reg != EE_IDLE) && !reload_mode_reg;

   // SRAM engine start and completion
   assign start_rise = ctrl_wr && BUS_REQ.wdata[BIT_SRAM_TEST_START] && !sram_run_reg;
   assign sram_event = SRAM_TEST_END && sram_run_reg && !sram_rst_reg && !fin_reg;

   // Final checksum sum over all bytes but the checksum low byte, plus the fixed constant
   assign final_sum = acc_reg + EE_CHECK_LOW + EE_DATA[15:8];

   // Register and SRAM test control next state
   always_comb begin
      sram_rst_next = sram_rst_reg;
      sram_run_next = sram_run_reg;
      fin_next = fin_reg;
      fault_next = fault_reg;
      mask_next = mask_reg;
      rdata_next = '0;
      if (ctrl_wr) begin
         // Only the two control bits store; other bits are dropped
         sram_rst_next = BUS_REQ.wdata[BIT_SRAM_TEST_RESET];
         sram_run_next = BUS_REQ.wdata[BIT_SRAM_TEST_START];
      end
      // Finished flag only while enabled and out of reset
      fin_next = sram_run_reg && !sram_rst_reg && !start_rise && (fin_reg || SRAM_TEST_END);
      // Faults collect during a run, clear on engine reset or restart
      if (sram_rst_reg || start_rise) begin
         fault_next = '0;
      end else if (sram_run_reg && !fin_reg) begin
         fault_next = fault_reg | SRAM_FAULTS;
      end
      // Sticky events, set beats write-one-to-clear
      status_next = status_reg & ~(status_wr ? BUS_REQ.wdata[EV_W-1:0] : {EV_W{1'b0}});
      status_next[EV_SRAM_DONE] = status_next[EV_SRAM_DONE] | sram_event;
      status_next[EV_CHECK_DONE] = status_next[EV_CHECK_DONE] | check_event;
      status_next[EV_RELOAD_DONE] = status_next[EV_RELOAD_DONE] | reload_event;
      if (mask_wr) begin
         mask_next = BUS_REQ.wdata[EV_W-1:0];
      end
      // Read data, unused bits zero
      if (BUS_REQ.rd) begin
         case (BUS_REQ.addr)
            OFS_SELF_TEST_CONTROL: begin
               rdata_next[BIT_SRAM_TEST_RESET] = sram_rst_reg;
               rdata_next[BIT_SRAM_TEST_START] = sram_run_reg;
               // Masked so a read right after disabling shows zero
               rdata_next[BIT_SRAM_TEST_FINISHED] = fin_reg && sram_run_reg && !sram_rst_reg;
               rdata_next[BIT_RX_FIFO_MEM_FAULT] = fault_reg.rx_fifo;
               rdata_next[BIT_TX_FIFO_MEM_FAULT] = fault_reg.tx_fifo;
               rdata_next[BIT_RX_FILTER_MEM_FAULT] = fault_reg.rx_filter;
               rdata_next[BIT_CONFIG_RELOAD_GO] = reload_busy;
               rdata_next[BIT_EEPROM_CHECK_GO] = check_busy;
               rdata_next[BIT_EEPROM_CHECK_BAD] = bad_reg;
            end
            OFS_EVENT_STATUS: rdata_next[EV_W-1:0] = status_reg;
            OFS_EVENT_MASK: rdata_next[EV_W-1:0] = mask_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   // Register and SRAM test control flops
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sram_rst_reg <= SELF_TEST_CONTROL_RESET[BIT_SRAM_TEST_RESET];
         sram_run_reg <= SELF_TEST_CONTROL_RESET[BIT_SRAM_TEST_START];
         fin_reg <= 1'b0;
         fault_reg <= '0;
         status_reg <= EVENT_RESET;
         mask_reg <= EVENT_RESET;
         rdata_reg <= '0;
      end else if (SOFT_RST) begin
         sram_rst_reg <= SELF_TEST_CONTROL_RESET[BIT_SRAM_TEST_RESET];
         sram_run_reg <= SELF_TEST_CONTROL_RESET[BIT_SRAM_TEST_START];
         fin_reg <= 1'b0;
         fault_reg <= '0;
         status_reg <= EVENT_RESET;
         mask_reg <= EVENT_RESET;
         rdata_reg <= '0;
      end else begin
         sram_rst_reg <= sram_rst_next;
         sram_run_reg <= sram_run_next;
         fin_reg <= fin_next;
         fault_reg <= fault_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
      end
   end

   // EEPROM sequencer next state
   always_comb begin
      state_next = state_reg;
      reload_mode_next = reload_mode_reg;
      bad_next = bad_reg;
      word_next = word_reg;
      acc_next = acc_reg;
      timer_next = (timer_reg == RELOAD_LAST) ? timer_reg : timer_reg + 1'b1;
      cfg_next = '0;
      check_event = 1'b0;
      reload_event = 1'b0;
      case (state_reg)
         EE_IDLE: begin
            timer_next = '0;
            // Go bits taken only while idle; reload wins if both set
            if (ctrl_wr && BUS_REQ.wdata[BIT_CONFIG_RELOAD_GO]) begin
               state_next = EE_FETCH;
               reload_mode_next = 1'b1;
               word_next = EE_FIRST_WORD;
               acc_next = '0;
            end else if (ctrl_wr && BUS_REQ.wdata[BIT_EEPROM_CHECK_GO]) begin
               state_next = EE_FETCH;
               reload_mode_next = 1'b0;
               bad_next = 1'b0;
               word_next = EE_FIRST_WORD;
               acc_next = '0;
            end
         end
         EE_FETCH: begin
            if (EE_ACK) begin
               if (word_reg == EE_LAST_WORD) begin
                  if (reload_mode_reg) begin
                     state_next = EE_WAIT;
                  end else begin
                     // Checksum word ends the check
                     bad_next = (EE_DATA[7:0] != EE_CHECK_LOW) || (final_sum != 8'h00);
                     check_event = 1'b1;
                     state_next = EE_IDLE;
                  end
               end else begin
                  acc_next = byte_sum(acc_reg, EE_DATA);
                  word_next = word_reg + 1'b1;
                  // Configuration written only on a reload
                  cfg_next.we = reload_mode_reg;
                  cfg_next.addr = word_reg;
                  cfg_next.data = EE_DATA;
               end
            end
         end
         EE_WAIT: begin
            // Busy indicator held for the full reload time
            if (timer_reg == RELOAD_LAST) begin
               reload_event = 1'b1;
               state_next = EE_IDLE;
            end
         end
         default: state_next = EE_IDLE;
      endcase
   end

   // EEPROM sequencer flops
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= EE_IDLE;
         reload_mode_reg <= 1'b0;
         bad_reg <= SELF_TEST_CONTROL_RESET[BIT_EEPROM_CHECK_BAD];
         word_reg <= EE_FIRST_WORD;
         acc_reg <= '0;
         timer_reg <= '0;
         cfg_reg <= '0;
      end else if (SOFT_RST) begin
         state_reg <= EE_IDLE;
         reload_mode_reg <= 1'b0;
         bad_reg <= SELF_TEST_CONTROL_RESET[BIT_EEPROM_CHECK_BAD];
         word_reg <= EE_FIRST_WORD;
         acc_reg <= '0;
         timer_reg <= '0;
         cfg_reg <= '0;
      end else begin
         state_reg <= state_next;
         reload_mode_reg <= reload_mode_next;
         bad_reg <= bad_next;
         word_reg <= word_next;
         acc_reg <= acc_next;
         timer_reg <= timer_next;
         cfg_reg <= cfg_next;
      end
   end

   // Outputs
   assign RDATA = rdata_reg;
   assign IRQ = |(status_reg & mask_reg);
   assign SRAM_TEST_RST = sram_rst_reg;
   assign SRAM_TEST_RUN = sram_run_reg;
   assign EE_REQ = (state_reg == EE_FETCH);
   assign EE_ADDR = word_reg;
   assign CFG_WR = cfg_reg;
endmodule

`default_nettype wire

// *** shared/self_test_pkg.sv ***
// Constants, register layout and carrier types of the self-test control block.
// Assumes a 200 MHz system clock and a 32-bit register port.
package self_test_pkg;
   // Register port widths and offsets
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_SELF_TEST_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_EVENT_STATUS = 8'h20;
   localparam logic [7:0] OFS_EVENT_MASK = 8'h24;
   localparam logic [31:0] SELF_TEST_CONTROL_RESET = 32'h00000000;
   localparam logic [2:0] EVENT_RESET = 3'h0;
   // Field positions of self_test_control
   localparam int BIT_SRAM_TEST_RESET = 10;
   localparam int BIT_SRAM_TEST_START = 7;
   localparam int BIT_SRAM_TEST_FINISHED = 6;
   localparam int BIT_RX_FIFO_MEM_FAULT = 5;
   localparam int BIT_TX_FIFO_MEM_FAULT = 4;
   localparam int BIT_RX_FILTER_MEM_FAULT = 3;
   localparam int BIT_CONFIG_RELOAD_GO = 2;
   localparam int BIT_EEPROM_CHECK_GO = 1;
   localparam int BIT_EEPROM_CHECK_BAD = 0;
   // Field positions of the event status and mask registers
   localparam int EV_SRAM_DONE = 0;
   localparam int EV_CHECK_DONE = 1;
   localparam int EV_RELOAD_DONE = 2;
   localparam int EV_W = 3;
   // EEPROM image layout
   localparam logic [3:0] EE_FIRST_WORD = 4'h0;
   localparam logic [3:0] EE_LAST_WORD = 4'hB;
   localparam logic [7:0] EE_CHECK_LOW = 8'h55;
   // Reload duration
   localparam int CLK_MHZ = 200;
   localparam int RELOAD_TIME_US = 1500;
   localparam int RELOAD_CYCLES = RELOAD_TIME_US * CLK_MHZ;
   localparam int TIMER_W = 19;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic rx_fifo;
      logic tx_fifo;
      logic rx_filter;
   } sram_fault_t;

   typedef struct packed {
      logic we;
      logic [3:0] addr;
      logic [15:0] data;
   } cfg_wr_t;

   typedef enum {EE_IDLE, EE_FETCH, EE_WAIT} ee_state_t;
endpackage

// *** verification/ee_sram_model.sv ***
// EEPROM word store and SRAM test engine model.
// BAD 1 spoils the checksum high byte, 2 the low byte.
`timescale 1ns/1ps
`default_nettype none
module ee_sram_model (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic EE_REQ,
   input wire logic [3:0] EE_ADDR,
   output logic EE_ACK,
   output logic [15:0] EE_DATA,
   input wire logic SRAM_TEST_RUN,
   input wire logic SRAM_TEST_RST,
   output logic SRAM_TEST_END,
   output self_test_pkg::sram_fault_t SRAM_FAULTS,
   input wire logic [1:0] BAD,
   input wire logic SLOW,
   input wire self_test_pkg::sram_fault_t FAULTS
);
   logic [1:0] gap_reg;
   logic [2:0] run_reg;
   // Image word, checksum in the last one
   function automatic logic [15:0] word(input logic [3:0] a);
      logic [7:0] s;
      logic [15:0] w;
      s = 8'h55;
      for (int i = 0; i < 11; i++) begin
         w = 16'h1234 + 16'(i) * 16'h0F0F;
         s = s + w[15:8] + w[7:0];
      end
      w = 16'h1234 + 16'(a) * 16'h0F0F;
      if (a == 4'hB) w = {8'h00 - s + 8'(BAD == 2'h1), BAD == 2'h2 ? 8'h54 : 8'h55};
      return w;
   endfunction
   // Word answer after 0 or 2 idle cycles; engine ends 4 cycles into a run
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         gap_reg <= 2'h0;
         run_reg <= 3'h0;
         EE_ACK <= 1'b0;
         EE_DATA <= 16'h0000;
      end else begin
         EE_ACK <= 1'b0;
         EE_DATA <= ~EE_DATA; // Stale word and its inverse alternate outside an answer
         gap_reg <= EE_REQ && !EE_ACK ? gap_reg + 2'h1 : 2'h0;
         if (EE_REQ && !EE_ACK && gap_reg == {SLOW, 1'b0}) begin
            EE_ACK <= 1'b1;
            EE_DATA <= word(EE_ADDR);
            gap_reg <= 2'h0;
         end
         if (!SRAM_TEST_RUN || SRAM_TEST_RST) run_reg <= 3'h0;
         else if (run_reg != 3'h4) run_reg <= run_reg + 3'h1;
      end
   end
   assign SRAM_TEST_END = run_reg == 3'h4;
   assign SRAM_FAULTS = SRAM_TEST_END ? FAULTS : '0;
endmodule
`default_nettype wire

// *** verification/self_test_ctrl_props.sv ***
// Port checker of the self-test control block.
// Bound into self_test_ctrl; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module self_test_ctrl_props (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic SOFT_RST,
   input wire self_test_pkg::bus_req_t BUS_REQ,
   input wire logic [31:0] RDATA,
   input wire logic SRAM_TEST_RST,
   input wire logic SRAM_TEST_RUN,
   input wire logic EE_REQ,
   input wire logic [3:0] EE_ADDR,
   input wire logic EE_ACK,
   input wire logic [15:0] EE_DATA,
   input wire self_test_pkg::cfg_wr_t CFG_WR
);
   import self_test_pkg::*;
   logic at_ctl;
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!ARST_N);
   // Control register addressed, no soft reset
   assign at_ctl = BUS_REQ.addr == OFS_SELF_TEST_CONTROL && !SOFT_RST;
   property p_unused; $past(BUS_REQ.rd) |-> RDATA[31:13] == 19'h0 && !RDATA[11]; endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
   property p_run; BUS_REQ.wr && at_ctl |=> SRAM_TEST_RUN == $past(BUS_REQ.wdata[7]); endproperty
   a_run: assert property (p_run) else $error("start bit not applied");
   property p_rst; BUS_REQ.wr && at_ctl |=> SRAM_TEST_RST == $past(BUS_REQ.wdata[10]); endproperty
   a_rst: assert property (p_rst) else $error("engine reset not applied");
   property p_idle; BUS_REQ.rd && at_ctl && !SRAM_TEST_RUN |=> !RDATA[6]; endproperty
   a_idle: assert property (p_idle) else $error("finished while disabled");
   property p_busy; BUS_REQ.rd && at_ctl && EE_REQ && !EE_ACK |=> RDATA[2:1] != 2'b00; endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_nocfg; BUS_REQ.wr && at_ctl && !EE_REQ && BUS_REQ.wdata[2:1] == 2'b01 |=> (!CFG_WR.we) [*8]; endproperty
   a_nocfg: assert property (p_nocfg) else $error("check wrote config");
   property p_last; EE_REQ && EE_ACK && EE_ADDR == EE_LAST_WORD |=> !EE_REQ; endproperty
   a_last: assert property (p_last) else $error("fetch past last word");
   property p_we; CFG_WR.we |-> $past(EE_ACK) && CFG_WR.addr <= 4'hA && CFG_WR.data == $past(EE_DATA); endproperty
   a_we: assert property (p_we) else $error("bad config write");
   c_ack_last: cover property (EE_ACK && EE_ADDR == EE_LAST_WORD);
   c_cfg: cover property (CFG_WR.we);
   c_run: cover property (SRAM_TEST_RUN && !SRAM_TEST_RST);
endmodule
bind self_test_ctrl self_test_ctrl_props u_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SOFT_RST(SOFT_RST),
   .BUS_REQ(BUS_REQ), .RDATA(RDATA), .SRAM_TEST_RST(SRAM_TEST_RST), .SRAM_TEST_RUN(SRAM_TEST_RUN),
   .EE_REQ(EE_REQ), .EE_ADDR(EE_ADDR), .EE_ACK(EE_ACK), .EE_DATA(EE_DATA), .CFG_WR(CFG_WR));
`default_nettype wire

// *** verification/test_sram_eeprom_test_control.sv ***
// Self-checking bench of the self-test control block.
// Far side is the model; registers over the plain port.
`timescale 1ns/1ps
`default_nettype none
module test_sram_eeprom_test_control;
   import self_test_pkg::*;
   logic clk_sys, arst_n, soft_rst, irq, s_rst, s_run, s_end, ee_req, ee_ack, slow;
   logic [31:0] rdata;
   logic [15:0] ee_data;
   logic [3:0] ee_addr;
   logic [1:0] bad;
   bus_req_t bus_req;
   sram_fault_t faults, s_flt;
   cfg_wr_t cfg_wr;
   int mismatches = 0, compares = 0, cfg_cnt = 0;
   self_test_ctrl #(.RELOAD_CYCLES_P(64)) u_self_test_ctrl (.CLK_SYS(clk_sys), .ARST_N(arst_n),
      .SOFT_RST(soft_rst), .BUS_REQ(bus_req), .RDATA(rdata), .IRQ(irq), .SRAM_TEST_RST(s_rst),
      .SRAM_TEST_RUN(s_run), .SRAM_TEST_END(s_end), .SRAM_FAULTS(s_flt), .EE_REQ(ee_req),
      .EE_ADDR(ee_addr), .EE_ACK(ee_ack), .EE_DATA(ee_data), .CFG_WR(cfg_wr));
   ee_sram_model u_ee_sram_model (.CLK_SYS(clk_sys), .ARST_N(arst_n), .EE_REQ(ee_req), .EE_ADDR(ee_addr),
      .EE_ACK(ee_ack), .EE_DATA(ee_data), .SRAM_TEST_RUN(s_run), .SRAM_TEST_RST(s_rst),
      .SRAM_TEST_END(s_end), .SRAM_FAULTS(s_flt), .BAD(bad), .SLOW(slow), .FAULTS(faults));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Tally of configuration word writes
   always @(posedge clk_sys) if (cfg_wr.we === 1'b1) cfg_cnt++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys) bus_req <= '{1'b1, 1'b0, a, v};
      @(posedge clk_sys) bus_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys) bus_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk_sys) bus_req <= '0;
      #1 chk(rdata, exp);
   endtask
   task automatic t_reset();
      rd(OFS_SELF_TEST_CONTROL, SELF_TEST_CONTROL_RESET);
      wr(OFS_SELF_TEST_CONTROL, 32'hFFFFE800);
      rd(OFS_SELF_TEST_CONTROL, 32'h0);
      rd(8'h40, 32'h0);
      wr(OFS_SELF_TEST_CONTROL, 32'h480);
      rd(OFS_SELF_TEST_CONTROL, 32'h480);
      @(posedge clk_sys) soft_rst <= 1'b1;
      @(posedge clk_sys) soft_rst <= 1'b0;
      rd(OFS_SELF_TEST_CONTROL, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_sram(input sram_fault_t f, input logic [31:0] exp);
      faults = f;
      wr(OFS_SELF_TEST_CONTROL, 32'h80);
      rd(OFS_SELF_TEST_CONTROL, 32'h80);
      for (int i = 0; i < 50 && !s_end; i++) #5;
      rd(OFS_SELF_TEST_CONTROL, exp);
      rd(OFS_EVENT_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_EVENT_MASK, 32'h1);
      #1 chk({31'h0, irq}, 32'h1);
      wr(OFS_EVENT_STATUS, 32'h1);
      #1 chk({31'h0, irq}, 32'h0);
      wr(OFS_EVENT_MASK, 32'h0);
      wr(OFS_SELF_TEST_CONTROL, 32'h400);
      rd(OFS_SELF_TEST_CONTROL, 32'h400);
      chk({31'h0, s_rst}, 32'h1);
      $display("sram test done");
   endtask
   task automatic t_check(input logic [1:0] b);
      bad = b;
      slow = b[0];
      wr(OFS_SELF_TEST_CONTROL, 32'h2);
      // Fail flag restarts at zero with each check
      rd(OFS_SELF_TEST_CONTROL, 32'h2);
      for (int i = 0; i < 200 && ee_req; i++) #5;
      rd(OFS_SELF_TEST_CONTROL, {31'h0, b != 2'h0});
      rd(OFS_EVENT_STATUS, 32'h2);
      wr(OFS_EVENT_STATUS, 32'h2);
      chk(32'(cfg_cnt), 32'h0);
      $display("check test done");
   endtask
   task automatic t_reload();
      slow = 1'b1;
      wr(OFS_SELF_TEST_CONTROL, 32'h6);
      rd(OFS_SELF_TEST_CONTROL, 32'h5);
      // Last busy cycle, then the first idle read
      repeat (60) @(posedge clk_sys);
      rd(OFS_SELF_TEST_CONTROL, 32'h5);
      rd(OFS_SELF_TEST_CONTROL, 32'h1);
      rd(OFS_EVENT_STATUS, 32'h4);
      wr(OFS_EVENT_MASK, 32'h4);
      #1 chk({31'h0, irq}, 32'h1);
      chk(32'(cfg_cnt), 32'd11);
      $display("reload test done");
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      arst_n = 1'b0;
      soft_rst = 1'b0;
      bus_req = '0;
      bad = 2'h0;
      slow = 1'b0;
      faults = '0;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_sram(3'b010, 32'hD0);
      t_sram(3'b111, 32'hF8);
      t_sram(3'b100, 32'hE0);
      for (int b = 0; b < 3; b++) t_check(2'(b));
      t_reload();
      conclude();
   end
   // Watchdog against a hang
   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
